//--- rtl/scs_pkg.sv
// Shared types and constants for the sample clock sequencer.
// Assumes one system clock domain plus an external pacing clock domain.
package scs_pkg;

    // Widths of counters and channel indices
    localparam int CNT_W = 16;
    localparam int CH_W = 4;

    // Synchroniser depth on every pin that enters the system domain
    localparam int SYNC_STAGES = 2;

    // Hardware trigger modes
    typedef enum logic [1:0] {
        scs_trig_off = 2'h0,
        scs_trig_single_shot = 2'h1,
        scs_trig_gate = 2'h2
    } scs_trig_e;

    // List clock mode: whole list per edge or one channel per edge
    localparam logic MODE_WHOLE_LIST = 1'h0;
    localparam logic MODE_SINGLE_CHAN = 1'h1;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        scs_st_idle = 4'h1,
        scs_st_armed = 4'h2,
        scs_st_wait = 4'h4,
        scs_st_list = 4'h8
    } scs_state_e;

    // Configuration captured when sampling starts
    typedef struct packed {
        logic list_clock_mode_select;   // 0 whole list, 1 single channel
        logic ext_clock_sel;            // 1 external pacing clock
        scs_trig_e hw_trigger_mode;     // Trigger handling
        logic [CH_W-1:0] last_chan;     // Channel count minus one
        logic [CNT_W-1:0] interval;     // Sample interval in cycles, min 1
        logic [CNT_W-1:0] timer_div;    // Internal pace period in cycles
        logic [CNT_W-1:0] sample_count; // Samples to take, 0 is unlimited
    } scs_cfg_s;

    // Reset values of the captured configuration
    localparam scs_cfg_s CFG_RESET = '{
        list_clock_mode_select: MODE_WHOLE_LIST,
        ext_clock_sel: 1'h0,
        hw_trigger_mode: scs_trig_off,
        last_chan: 4'h0,
        interval: 16'h0001,
        timer_div: 16'h0001,
        sample_count: 16'h0000
    };

endpackage

//--- rtl/scs_sequencer.sv
// Sample clock sequencer: paces conversions over a channel list.
// Assumes ext_clk may stop between edges; trigger pin is asynchronous.
// The converter answers adc_data combinationally in the issuing cycle.
//
// Overview of operation
// - Act on external clock rising edges only; falling edges do nothing.
// - Whole-list mode: each rising edge starts the list, first channel at once.
// - Whole-list mode: later channels follow in order, one interval apart.
// - Single-channel mode: each rising edge converts one channel, in list order.
// - Single-channel mode: after the last channel the first comes again.
// - Mode setting picks whole-list or single-channel; whole-list after reset.
// - External clock paces only when selected; otherwise internal timer paces.
// - No maximum external clock period; wait forever for the next edge.
// - One pipeline stage: sample returned in the cycle it is acquired.
// - No extra conversion cycle issued when sampling stops.
// - Shared with flush-dependent units, this block follows the clock.
// - Dedicated trigger line starts and stops sampling; nothing before trigger.
// - Trigger offers single-shot and level gate modes.
// - Internal crystal-derived timer paces when external clock not selected.
// - Same two clock modes serve input and output sequencing instances.
// - Single-shot: start once trigger high, run until stop or count.
// - Gate: run while trigger high; whole-list halts only at list boundary.
`timescale 1ns/10ps

module scs_sequencer #(
    parameter int CNT_W = scs_pkg::CNT_W,
    parameter int CH_W = scs_pkg::CH_W,
    parameter int DATA_W = 16
) (
    input wire logic ref_clk,                  // System clock, 25 MHz
    input wire logic rst,                      // Asynchronous reset, active high
    input wire logic ext_clk,                  // External pacing clock
    input wire logic trig_pin,                 // Hardware trigger line
    input wire logic start,                    // Start request, one cycle
    input wire logic stop,                     // Stop request, one cycle
    input wire scs_pkg::scs_cfg_s cfg,         // Configuration taken at start
    input wire logic [DATA_W-1:0] adc_data,    // Converter result, same cycle
    output logic conv_strobe,                  // Conversion issued, one cycle
    output logic [CH_W-1:0] conv_chan,         // Channel of that conversion
    output logic sample_valid,                 // Sample returned, one cycle
    output logic [DATA_W-1:0] sample_data,     // Acquired sample
    output logic running,                      // Sampling active
    output logic armed                         // Waiting for single-shot trigger
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    scs_pkg::scs_state_e state;
    scs_pkg::scs_cfg_s cfg_q;
    logic ext_tgl;
    logic ext_s1, ext_s2, ext_q;
    logic trig_s1, trig_s2;
    logic ext_rise;
    logic tick;
    logic pace;
    logic gate_ok;
    logic issue;
    logic list_end;
    logic count_end;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] ivl;
    logic [CNT_W-1:0] done_cnt;
    logic [CH_W-1:0] chan;
    logic [CH_W-1:0] next_chan;

    // Wrap to zero after the last channel of the list
    function automatic logic [CH_W-1:0] chan_step(input logic [CH_W-1:0] c,
                                                  input logic [CH_W-1:0] last);
        chan_step = (c == last) ? '0 : c + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link domain: each rising edge flips a toggle, falling edges unseen

    always_ff @(posedge ext_clk or posedge rst)
    begin
        if (rst)
            ext_tgl <= 1'b0;
        else
            ext_tgl <= ~ext_tgl;
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings into ref_clk; the toggle survives a stopped link clock

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_q <= 1'b0;
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
        end
        else
        begin
            ext_s1 <= ext_tgl;
            ext_s2 <= ext_s1;
            ext_q <= ext_s2;
            trig_s1 <= trig_pin;
            trig_s2 <= trig_s1;
        end
    end

    // Edge of the synchronised toggle marks one external rising edge
    assign ext_rise = ext_s2 ^ ext_q;

    ////////////////////////////////////////////////////////////////////////
    // Internal pacing timer, preloaded from the incoming setting while idle
    // so the first tick is one full new period after start, not the old one

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            tmr <= '0;
        else if (state == scs_pkg::scs_st_idle)
            tmr <= cfg.timer_div - 1'b1;
        else if (tmr == '0)
            tmr <= cfg_q.timer_div - 1'b1;
        else
            tmr <= tmr - 1'b1;
    end

    assign tick = (state != scs_pkg::scs_st_idle) && (tmr == '0);

    ////////////////////////////////////////////////////////////////////////
    // Issue decision; stop outranks any pending conversion

    // External pacing only when selected; a follower never sources the clock
    assign pace = cfg_q.ext_clock_sel ? ext_rise : tick;
    // Gate checked only at boundaries, i.e. while waiting for a pace event
    assign gate_ok = (cfg_q.hw_trigger_mode != scs_pkg::scs_trig_gate) || trig_s2;
    assign issue = !stop &&
        ((state == scs_pkg::scs_st_wait && pace && gate_ok) ||
         (state == scs_pkg::scs_st_list && ivl == '0));
    assign list_end = (chan == cfg_q.last_chan);
    assign count_end = (cfg_q.sample_count != '0) &&
        (done_cnt == cfg_q.sample_count - 1'b1);
    assign next_chan = chan_step(chan, cfg_q.last_chan);

    ////////////////////////////////////////////////////////////////////////
    // Configuration capture; reset value selects whole-list clocking

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cfg_q <= scs_pkg::CFG_RESET;
        else if (state == scs_pkg::scs_st_idle && start)
            cfg_q <= cfg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state; waiting has no timeout by design

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state <= scs_pkg::scs_st_idle;
        else
        begin
            case (state)
                scs_pkg::scs_st_idle:
                begin
                    if (start && !stop)
                    begin
                        if (cfg.hw_trigger_mode == scs_pkg::scs_trig_single_shot)
                            state <= scs_pkg::scs_st_armed;
                        else
                            state <= scs_pkg::scs_st_wait;
                    end
                end
                scs_pkg::scs_st_armed:
                begin
                    if (stop)
                        state <= scs_pkg::scs_st_idle;
                    else if (trig_s2)
                        state <= scs_pkg::scs_st_wait;
                end
                scs_pkg::scs_st_wait:
                begin
                    // No timer bounds this wait: slow clocks are legal
                    if (stop || (issue && count_end))
                        state <= scs_pkg::scs_st_idle;
                    else if (issue && cfg_q.list_clock_mode_select ==
                             scs_pkg::MODE_WHOLE_LIST && !list_end)
                        state <= scs_pkg::scs_st_list;
                end
                scs_pkg::scs_st_list:
                begin
                    if (stop || (issue && count_end))
                        state <= scs_pkg::scs_st_idle;
                    else if (issue && list_end)
                        state <= scs_pkg::scs_st_wait;
                end
                default:
                    state <= scs_pkg::scs_st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interval counter: each list channel one interval after the previous

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ivl <= '0;
        else if (issue)
            ivl <= cfg_q.interval - 1'b1;
        else if (ivl != '0)
            ivl <= ivl - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel pointer; a new run begins at channel zero

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            chan <= '0;
        else if (state == scs_pkg::scs_st_idle)
            chan <= '0;
        else if (issue)
            chan <= next_chan;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample counter for the sample count limit, used in every trigger mode

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            done_cnt <= '0;
        else if (state == scs_pkg::scs_st_idle)
            done_cnt <= '0;
        else if (issue)
            done_cnt <= done_cnt + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: sample captured in the issuing cycle, no flush cycle at stop

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            conv_strobe <= 1'b0;
            conv_chan <= '0;
            sample_valid <= 1'b0;
            sample_data <= '0;
        end
        else
        begin
            conv_strobe <= issue;
            sample_valid <= issue;
            if (issue)
            begin
                conv_chan <= chan;
                sample_data <= adc_data;
            end
        end
    end

    // Status flags
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            running <= 1'b0;
            armed <= 1'b0;
        end
        else
        begin
            running <= (state == scs_pkg::scs_st_wait) || (state == scs_pkg::scs_st_list);
            armed <= (state == scs_pkg::scs_st_armed);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    no_pre_trig_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == scs_pkg::scs_st_armed) |=> !conv_strobe)
        else $error("conversion issued before trigger");

    stop_no_flush_a: assert property (@(posedge ref_clk) disable iff (rst)
        stop |=> !conv_strobe ##1 !conv_strobe)
        else $error("conversion after stop");

    list_edge_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == scs_pkg::scs_st_wait && cfg_q.ext_clock_sel && ext_rise && gate_ok
         && !stop) |=> (conv_strobe && conv_chan == $past(chan)))
        else $error("edge did not start conversion");

    list_spacing_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == scs_pkg::scs_st_list && ivl == 16'h0001 && !stop ##1 !stop)
        |=> conv_strobe)
        else $error("list channel not on interval");

    single_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
        (issue && cfg_q.list_clock_mode_select == scs_pkg::MODE_SINGLE_CHAN &&
         chan == cfg_q.last_chan) |=> (chan == '0 || state == scs_pkg::scs_st_idle))
        else $error("single channel list did not wrap");

    single_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        (issue && cfg_q.list_clock_mode_select == scs_pkg::MODE_SINGLE_CHAN)
        |=> state != scs_pkg::scs_st_list)
        else $error("single channel mode ran a list");

    int_pace_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == scs_pkg::scs_st_wait && !cfg_q.ext_clock_sel && !tick)
        |=> !conv_strobe)
        else $error("internal mode issued without timer tick");

    gate_halt_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state == scs_pkg::scs_st_wait && cfg_q.hw_trigger_mode ==
         scs_pkg::scs_trig_gate && !trig_s2) |=> !conv_strobe)
        else $error("gate low but conversion issued");

    same_cycle_a: assert property (@(posedge ref_clk) disable iff (rst)
        conv_strobe |-> (sample_valid && sample_data == $past(adc_data)))
        else $error("sample not returned with its conversion");

    count_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (issue && count_end) |=> ##1 (state == scs_pkg::scs_st_idle && !running))
        else $error("count limit did not stop sampling");

    trig_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(trig_s2) |-> $past(trig_pin, 2))
        else $error("trigger not passed through synchroniser");

    reset_mode_a: assert property (@(posedge ref_clk)
        $fell(rst) |-> cfg_q.list_clock_mode_select == scs_pkg::MODE_WHOLE_LIST)
        else $error("whole list mode not default");

    whole_list_c: cover property (@(posedge ref_clk) disable iff (rst)
        state == scs_pkg::scs_st_list ##[1:1000] state == scs_pkg::scs_st_wait);

    single_wrap_c: cover property (@(posedge ref_clk) disable iff (rst)
        issue && cfg_q.list_clock_mode_select == scs_pkg::MODE_SINGLE_CHAN &&
        list_end && cfg_q.last_chan != '0);

    trig_start_c: cover property (@(posedge ref_clk) disable iff (rst)
        state == scs_pkg::scs_st_armed ##1 state == scs_pkg::scs_st_wait);

    stop_mid_list_c: cover property (@(posedge ref_clk) disable iff (rst)
        state == scs_pkg::scs_st_list && stop);

endmodule // scs_sequencer

//--- verification/scs_far_side.sv
// Far-side model: external pacing clock source and hardware trigger driver.
// Assumes the bench spaces pulse requests wider than one list or channel.
`timescale 1ns/10ps

module scs_far_side (
    input wire logic pulse_req,   // Each toggle asks for one clock cycle
    input wire logic trig_req,    // Requested trigger level
    output logic ext_clk,         // Pacing clock, still low between frames
    output wire logic trig_pin    // Trigger line to the sequencer
);

    ////////////////////////////////////////////////////////////////////////////
    // One 30 ns cycle per request at random phase; this side owns the clock
    // Request spacing is left to the bench, which keeps the period limits
    initial
    begin
        ext_clk = 1'h0;
        forever
        begin
            @(pulse_req);
            #($urandom_range(1, 20));
            ext_clk = 1'h1;
            #15;
            ext_clk = 1'h0;
            #15;
        end
    end

    // Trigger skewed so it never lines up with the system clock edge
    assign #7 trig_pin = trig_req;

endmodule // scs_far_side

//--- verification/scs_sequencer_tb.sv
// Self-checking bench for the sample clock sequencer.
// Assumes the far-side model file is compiled first; converter data is random.
`timescale 1ns/10ps

module scs_sequencer_tb;

    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic start = 1'h0;
    logic stop = 1'h0;
    logic pulse_req = 1'h0;
    logic trig_req = 1'h0;
    logic [15:0] adc_data = 16'h0000;
    scs_pkg::scs_cfg_s cfg = scs_pkg::CFG_RESET;
    logic ext_clk;
    wire logic trig_pin;
    logic conv_strobe;
    logic [scs_pkg::CH_W-1:0] conv_chan;
    logic sample_valid;
    logic [15:0] sample_data;
    logic running;
    logic armed;
    logic [15:0] adc_last = 16'h0000;
    logic [scs_pkg::CH_W-1:0] q_chan[$];
    int q_cyc[$];
    int pc[16];
    int cyc = 0;
    int start_cyc = 0;
    int err_count = 0;
    int comparisons = 0;

    scs_sequencer #(.DATA_W(16)) u_dut (.ref_clk(ref_clk), .rst(rst), .ext_clk(ext_clk),
        .trig_pin(trig_pin), .start(start), .stop(stop), .cfg(cfg), .adc_data(adc_data),
        .conv_strobe(conv_strobe), .conv_chan(conv_chan), .sample_valid(sample_valid),
        .sample_data(sample_data), .running(running), .armed(armed));

    scs_far_side u_far (.pulse_req(pulse_req), .trig_req(trig_req), .ext_clk(ext_clk),
        .trig_pin(trig_pin));

    ////////////////////////////////////////////////////////////////////////////
    // System clock, 25 MHz
    always #20 ref_clk = ~ref_clk;

    // Fresh converter value every cycle, so a stale capture shows up
    always @(posedge ref_clk) adc_data <= #1 16'($urandom);

    // Record every conversion and its cycle; sample must be that cycle's data
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (conv_strobe === 1'h1 || sample_valid === 1'h1)
        begin
            check("sample_valid", sample_valid, conv_strobe);
            check("sample_data", sample_data, adc_last);
            q_chan.push_back(conv_chan);
            q_cyc.push_back(cyc);
        end
        adc_last = adc_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic begin_run(input scs_pkg::scs_cfg_s c);
        q_chan.delete();
        q_cyc.delete();
        cfg = c;
        start = 1'h1;
        step(1);
        start_cyc = cyc;
        start = 1'h0;
    endtask

    // Stop must not leave a trailing flush conversion behind
    task automatic end_run();
        int n;
        stop = 1'h1;
        step(1);
        stop = 1'h0;
        n = q_chan.size();
        step(40);
        check("stop_count", q_chan.size(), n);
        check("stop_running", running, 1'h0);
    endtask

    // Bounded wait; running out of cycles ends the run as a failure
    task automatic wait_count(input int n, input int bound);
        for (int i = 0; i < bound && q_chan.size() < n; i++)
            step(1);
        if (q_chan.size() < n)
        begin
            check("strobe_wait", q_chan.size(), n);
            test_done();
        end
    endtask

    // Expected channel of the i-th conversion since start
    function automatic int exp_chan(input int i, input int nch);
        return i % nch;
    endfunction

    // Channel order and spacing; pace of 0 skips the pace check
    task automatic check_seq(input int nch, input int gap, input int pace, input logic whole);
        for (int i = 0; i < q_chan.size(); i++)
        begin
            check("conv_chan", q_chan[i], exp_chan(i, nch));
            if (i > 0 && whole && i % nch != 0)
                check("chan_gap", q_cyc[i] - q_cyc[i-1], gap);
            else if (i >= nch && whole && pace > 0)
                check("list_pace", q_cyc[i] - q_cyc[i-nch], pace);
            else if (i > 0 && !whole && pace > 0)
                check("chan_pace", q_cyc[i] - q_cyc[i-1], pace);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: internal pacing, external pacing, single shot, gate
    initial
    begin
        scs_pkg::scs_cfg_s c;
        int nch;
        int np;
        int n;
        void'($urandom(95));
        step(20);
        rst = 1'h0;
        check("reset_running", running, 1'h0);
        step(2);
        for (int m = 0; m < 2; m++)
        begin
            c = scs_pkg::CFG_RESET;
            c.list_clock_mode_select = m[0];
            c.last_chan = 4'($urandom_range(1, 3));
            c.interval = 16'($urandom_range(2, 5)); // Short stand-in for settling
            c.timer_div = 16'((c.last_chan + 2) * c.interval + $urandom_range(3, 9));
            nch = c.last_chan + 1;
            begin_run(c);
            wait_count(m ? nch + 2 : 3 * nch, 600);
            // Strobe seen one edge after it launches, one after the tick
            check("first_tick", q_cyc[0] - start_cyc, c.timer_div + 1);
            check_seq(nch, c.interval, c.timer_div, !m[0]);
            end_run();
            $display("test internal pacing mode %0d done", m);
        end
        for (int m = 0; m < 2; m++)
        begin
            c = scs_pkg::CFG_RESET;
            c.list_clock_mode_select = m[0];
            c.ext_clock_sel = 1'h1;
            c.timer_div = 16'h0003;
            c.last_chan = 4'($urandom_range(1, 4));
            c.interval = 16'($urandom_range(2, 4));
            nch = c.last_chan + 1;
            begin_run(c);
            step(60);
            check("ext_idle", q_chan.size(), 0);
            np = m ? nch + 2 : 3;
            for (int p = 0; p < np; p++)
            begin
                pc[p] = cyc;
                pulse_req = ~pulse_req;
                // Spacing keeps the far-side period limits
                step(m ? c.interval + 12 : nch * c.interval + 12 + $urandom_range(0, 30));
            end
            check("ext_count", q_chan.size(), m ? np : np * nch);
            check_seq(nch, c.interval, 0, !m[0]);
            for (int p = 0; p < np; p++)
                check("ext_sync", (q_cyc[m ? p : p * nch] - pc[p]) inside {[2:9]}, 1'h1);
            end_run();
            $display("test external pacing mode %0d done", m);
        end
        c = scs_pkg::CFG_RESET;
        c.hw_trigger_mode = scs_pkg::scs_trig_single_shot;
        c.list_clock_mode_select = 1'h1;
        c.last_chan = 4'h3;
        c.timer_div = 16'h0004;
        c.sample_count = 16'($urandom_range(2, 6));
        begin_run(c);
        step(40);
        check("armed", armed, 1'h1);
        check("pre_trigger", q_chan.size(), 0);
        trig_req = 1'h1;
        wait_count(c.sample_count, 300);
        step(20);
        check("shot_count", q_chan.size(), c.sample_count);
        check("shot_end", running, 1'h0);
        check_seq(4, 0, 4, 1'h0);
        trig_req = 1'h0;
        end_run();
        $display("test single shot done");
        c = scs_pkg::CFG_RESET;
        c.hw_trigger_mode = scs_pkg::scs_trig_gate;
        c.last_chan = 4'h2;
        c.interval = 16'h0002;
        c.timer_div = 16'h000c;
        begin_run(c);
        step(60);
        check("gate_low", q_chan.size(), 0);
        trig_req = 1'h1;
        wait_count(3, 100);
        step($urandom_range(20, 60));
        trig_req = 1'h0;
        step(60);
        n = q_chan.size();
        check("gate_list", n % 3, 0);
        step(60);
        check("gate_halt", q_chan.size(), n);
        check_seq(3, 2, 0, 1'h1);
        end_run();
        $display("test gate done");
        test_done();
    end

endmodule // scs_sequencer_tb
